// ==== rtl/pim_pkg.sv ====
// Purpose: constants shared by the interrupt collection logic
// Assumes: 100 MHz sys_clk, 8-bit register port with 5-bit index
// Notes:   group index g matches summary bit g for groups 0..6
// Overview of operation
// [R1] event sets latch, holds until software clears
// [R2] latches readable; write one clears bit
// [R3] masked latch never drives interrupt output
// [R4] unmasked set latch drives output low
// [R5] live bits show present unlatched source level
// [R6] summary bit set by unmasked latch in group
// [R7] summary bit clears itself with its latches
// [R8] output held until all unmasked latches clear
// [R9] summary bit order fixed, warning at top
// [R10] regulators 3..1 at bits 2..0, four groups
// [R11] early warning flag; fuse picks lead time
// [R12] bypassed fault still latches and interrupts
// [R13] button hold latches at 1,2,3,4,8 s
// [R14] zero writes ignored; event beats clear
// [R15] reserved bits read zero, ignore writes
package pim_pkg;
    localparam int        NUM_GROUPS  = 7;             // second-level groups
    // register indices on the register port
    localparam logic [4:0] LATCH_BASE = 5'h00;         // latch of group g at base+g
    localparam logic [4:0] MASK_BASE  = 5'h08;         // mask of group g at base+g
    localparam logic [4:0] LIVE_BASE  = 5'h10;         // live of group g at base+g
    localparam logic [4:0] EN_LIVE    = 5'h17;         // enable pin live bits
    localparam logic [4:0] SUMMARY    = 5'h18;         // first-level summary
    // group numbering, equal to summary bit position
    localparam int G_STATUS1 = 0;
    localparam int G_THERMAL = 1;
    localparam int G_MODE    = 2;
    localparam int G_ILIM    = 3;
    localparam int G_UV      = 4;
    localparam int G_OV      = 5;
    localparam int G_BUTTON  = 6;
    localparam int EWARN_BIT = 7;
    // implemented bits per group, latch/mask and live
    localparam logic [7:0] LATCH_VALID [NUM_GROUPS] = '{8'hfb, 8'hff, 8'h07, 8'h07, 8'h07, 8'h07, 8'hff};
    localparam logic [7:0] LIVE_VALID  [NUM_GROUPS] = '{8'h03, 8'hff, 8'h00, 8'h07, 8'h07, 8'h07, 8'h81};
    localparam logic [7:0] MASK_RESET  = 8'hff;        // everything masked after reset
    localparam logic [7:0] EN_VALID    = 8'h07;
    // timing
    localparam int CLK_MHZ       = 100;
    localparam int MS_PER_SEC    = 1000;
    localparam int TICK_MS       = 1;                  // hold counter resolution, ms
    localparam int HOLD_S [5]    = '{1, 2, 3, 4, 8};   // button hold thresholds, s
    localparam int EWARN_T0_US   = 100;                // lead times, us
    localparam int EWARN_T1_US   = 5000;
    localparam int EWARN_T2_US   = 20000;
    localparam int EWARN_T3_US   = 50000;
    localparam int MS_CYCLES     = TICK_MS * 1000 * CLK_MHZ;
    localparam int EWARN_C0      = EWARN_T0_US * CLK_MHZ;
    localparam int EWARN_C1      = EWARN_T1_US * CLK_MHZ;
    localparam int EWARN_C2      = EWARN_T2_US * CLK_MHZ;
    localparam int EWARN_C3      = EWARN_T3_US * CLK_MHZ;
endpackage

// ==== rtl/pim_interrupt_core.sv ====
// Purpose: two-level interrupt latches, masks, live bits and summary
// Assumes: all inputs synchronous to sys_clk; event inputs are pulses
// Notes:   interrupt and read data are registered; read data follows addr
`timescale 1ns/1ps
module pim_interrupt_core #(
    parameter int MS_CYCLES_P = pim_pkg::MS_CYCLES,    // cycles per hold tick
    parameter int EWARN_C0_P  = pim_pkg::EWARN_C0,     // lead time counts per fuse code
    parameter int EWARN_C1_P  = pim_pkg::EWARN_C1,
    parameter int EWARN_C2_P  = pim_pkg::EWARN_C2,
    parameter int EWARN_C3_P  = pim_pkg::EWARN_C3
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [4:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // event pulses per group
    input  wire logic [7:0] status1_event,
    input  wire logic [7:0] thermal_event,
    input  wire logic [2:0] mode_event,
    input  wire logic [2:0] ilim_event,
    input  wire logic [2:0] uv_event,
    input  wire logic [2:0] ov_event,
    input  wire logic       push_event,
    input  wire logic       release_event,
    input  wire logic       bandgap_event,
    // live levels
    input  wire logic [1:0] status1_level,
    input  wire logic [7:0] thermal_level,
    input  wire logic [2:0] ilim_level,
    input  wire logic [2:0] uv_level,
    input  wire logic [2:0] ov_level,
    input  wire logic       bandgap_level,
    input  wire logic       push_button_input,
    input  wire logic [2:0] enable_pin_level,
    // early warning
    input  wire logic       shutdown_request,
    input  wire logic [1:0] warning_lead_time_fuse,
    output logic            shutdown_now,
    output logic            interrupt_request_low_n
);
    import pim_pkg::*;

    // index map, one byte each:
    //   0x00+g  latch of group g, w1c
    //   0x08+g  mask of group g
    //   0x10+g  live levels of group g
    //   0x17    enable pin levels
    //   0x18    summary, bit 7 warning
    //   others  read zero, writes lost
    // groups: status1, thermal, mode,
    //   ilim, uv, ov, push button
    // host flow: read summary, read the
    // flagged latches, write ones back;
    // the pin lets go on the edge that
    // clears the last unmasked latch
    // masks are all set after reset, so
    // no latch pulls the pin until the
    // host opens them; latches still
    // collect events in the meantime
    // events are one-cycle pulses; a
    // level held high keeps setting its
    // latch, so a clear cannot stick
    // hold latches set up to one tick
    // after their threshold, not before
    // a read returns the register as it
    // stood at the previous edge
    // early warning: a request sets bit 7
    // and pulls the pin at once; shutdown
    // follows after the fused lead time,
    // which is the host's time to save
    // its state; bit 7 stays set after
    // the pulse until written with a one
    // all logic runs on sys_clk; the hold
    // timer divides it with a one-cycle enable
    // the summary holds no state except
    // bit 7; its other bits are worked out
    // from the latches and masks on read
    // so they clear with them, unasked
    // the pin is the or of every unmasked
    // latch and the warning flag; masking
    // a latch hides it from pin and summary
    // alike, but the latch keeps its value

    // per-group state and gathered inputs,
    // indexed by group number
    logic [7:0]  latch      [NUM_GROUPS];              // second-level latches
    logic [7:0]  next_latch [NUM_GROUPS];
    logic [7:0]  mask       [NUM_GROUPS];              // second-level masks
    logic [7:0]  next_mask  [NUM_GROUPS];
    logic [7:0]  event_vec  [NUM_GROUPS];              // gathered event pulses
    logic [7:0]  live_vec   [NUM_GROUPS];              // gathered live levels
    logic [6:0]  next_group;                           // unmasked-pending per group
    logic        ewarn;                                // early warning flag
    logic        next_ewarn;
    logic [7:0]  next_rdata;
    logic        next_irq_n;
    // button hold timer, early warning
    // countdown and the read path
    logic [4:0]  hold_event;                           // button hold crossings
    logic [31:0] ms_cnt;                               // divider for ms tick
    logic [31:0] next_ms_cnt;
    logic [13:0] hold_ms;                              // ms the button has been low
    logic [13:0] next_hold_ms;
    logic        ms_tick;
    logic [22:0] warn_cnt;                             // lead time countdown
    logic [22:0] next_warn_cnt;
    logic        next_shutdown;
    logic [22:0] lead_cycles;

    // gather inputs into per-group vectors, regulator n at bit n-1
    // narrow groups are padded low here and trimmed
    // again by the valid masks on the way out
    always_comb begin
        event_vec[G_STATUS1] = status1_event;
        event_vec[G_THERMAL] = thermal_event;
        event_vec[G_MODE]    = {5'h00, mode_event};     // R10
        event_vec[G_ILIM]    = {5'h00, ilim_event};     // R10
        event_vec[G_UV]      = {5'h00, uv_event};       // R10
        event_vec[G_OV]      = {5'h00, ov_event};       // R10
        // hold latches come from the internal hold timer
        event_vec[G_BUTTON]  = {bandgap_event, hold_event, release_event, push_event}; // R13
        live_vec[G_STATUS1]  = {6'h00, status1_level};  // R5
        live_vec[G_THERMAL]  = thermal_level;           // R5
        live_vec[G_MODE]     = 8'h00;                   // no live bits here
        live_vec[G_ILIM]     = {5'h00, ilim_level};     // R5
        live_vec[G_UV]       = {5'h00, uv_level};       // R5
        live_vec[G_OV]       = {5'h00, ov_level};       // R5
        live_vec[G_BUTTON]   = {bandgap_level, 6'h00, push_button_input}; // R5
    end

    // per-group latch and mask next values
    // fault bypass is upstream; events arrive here whether bypassed or not
    // a bypass only skips the protection actions;
    // the fault must still latch and pull the pin
    // every group gets its own copy of this logic
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        logic [7:0] clr_bits;
        logic       mask_wr;
        always_comb begin
            // zero bits in the write leave latches alone
            clr_bits = (reg_wr && reg_addr == LATCH_BASE + 5'(g)) ? reg_wdata : 8'h00; // R2 R14
            mask_wr  = reg_wr && reg_addr == MASK_BASE + 5'(g);
            // set wins over clear in the same cycle
            next_latch[g] = ((latch[g] & ~clr_bits) | event_vec[g]) & LATCH_VALID[g]; // R1 R12 R14 R15
            next_mask[g]  = mask_wr ? (reg_wdata & LATCH_VALID[g]) : mask[g];          // R15
            // pin term follows next latches so it clears with them
            next_group[g] = |(next_latch[g] & ~next_mask[g]);                          // R3 R6 R7
        end
    end

    // early warning flag: set by request, cleared by write one to summary bit 7
    // the pin term uses next values, so it drops
    // and releases on the same edge as the latches
    always_comb begin
        next_ewarn = ewarn;
        if (reg_wr && reg_addr == SUMMARY && reg_wdata[EWARN_BIT]) begin
            next_ewarn = 1'b0;
        end
        if (shutdown_request) begin
            next_ewarn = 1'b1;                           // R11
        end
        // output is the or of all pending summary bits
        next_irq_n = ~(|next_group | next_ewarn);        // R4 R8
    end

    // lead time countdown, chosen by the fuse code
    // a request while counting only sets the flag;
    // a restart would let a chattering source put
    // the shutdown off for ever
    always_comb begin
        case (warning_lead_time_fuse)
            2'b00:   lead_cycles = 23'(EWARN_C0_P);      // R11
            2'b01:   lead_cycles = 23'(EWARN_C1_P);
            2'b10:   lead_cycles = 23'(EWARN_C2_P);
            default: lead_cycles = 23'(EWARN_C3_P);
        endcase
        next_warn_cnt = warn_cnt;
        next_shutdown = 1'b0;
        if (shutdown_request && warn_cnt == 23'h000000) begin
            next_warn_cnt = lead_cycles;                 // a request while counting is ignored
        end else if (warn_cnt != 23'h000000) begin
            next_warn_cnt = warn_cnt - 23'h000001;
            next_shutdown = (warn_cnt == 23'h000001);    // one-cycle pulse at expiry
        end
    end

    // button hold timer, counting whole ms while the input is low
    // both counts restart on release, so a short
    // press then a long one times the second press
    // the ms count stops past the last threshold
    always_comb begin
        ms_tick      = (ms_cnt == 32'(MS_CYCLES_P - 1));
        next_ms_cnt  = 32'h00000000;
        next_hold_ms = 14'h0000;
        if (!push_button_input) begin
            next_ms_cnt  = ms_tick ? 32'h00000000 : ms_cnt + 32'h00000001;
            next_hold_ms = hold_ms;
            // saturate just past the longest threshold so it fires once
            if (ms_tick && hold_ms <= 14'(HOLD_S[4] * MS_PER_SEC)) begin
                next_hold_ms = hold_ms + 14'h0001;
            end
        end
    end

    // hold crossings: strictly longer than each threshold
    // each crossing is one pulse, so a hold latch
    // sets at most once per press
    for (genvar h = 0; h < 5; h++) begin : g_hold
        assign hold_event[h] = ms_tick && !push_button_input &&
                               hold_ms == 14'(HOLD_S[h] * MS_PER_SEC); // R13
    end

    // read data, reserved bits forced to zero
    // the index alone picks the data; a write in
    // the same cycle is not seen by that read
    // live levels pass the valid table first
    always_comb begin
        next_rdata = 8'h00;                              // unused indices read zero
        for (int i = 0; i < NUM_GROUPS; i++) begin
            if (reg_addr == LATCH_BASE + 5'(i)) next_rdata = latch[i];                    // R2
            if (reg_addr == MASK_BASE + 5'(i))  next_rdata = mask[i];
            if (reg_addr == LIVE_BASE + 5'(i))  next_rdata = live_vec[i] & LIVE_VALID[i]; // R5 R15
        end
        if (reg_addr == EN_LIVE) next_rdata = {5'h00, enable_pin_level} & EN_VALID;       // R5
        if (reg_addr == SUMMARY) next_rdata = {ewarn, sum_bits()};                        // R9
    end

    // summary of current latches, group g at bit g
    // uses the registered latches, so a read in
    // the cycle of an event shows the old state
    function automatic logic [6:0] sum_bits();
        logic [6:0] s;
        s = 7'h00;
        for (int i = 0; i < NUM_GROUPS; i++) begin
            s[i] = |(latch[i] & ~mask[i]);               // R6 R7
        end
        return s;
    endfunction

    // state registers, one process per group of
    // state; each only copies the next values,
    // and every reset value is a constant
    // latches and masks; reserved mask bits
    // leave reset at zero so they read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_GROUPS; i++) begin
                latch[i] <= 8'h00;                       // nothing pending
                mask[i]  <= MASK_RESET & LATCH_VALID[i]; // R15
            end
        end else begin
            for (int i = 0; i < NUM_GROUPS; i++) begin
                latch[i] <= next_latch[i];               // R1
                mask[i]  <= next_mask[i];
            end
        end
    end

    // warning flag and interrupt pin; the pin
    // is released while reset is held
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ewarn                   <= 1'b0;
            interrupt_request_low_n <= 1'b1;
        end else begin
            ewarn                   <= next_ewarn;       // R11
            interrupt_request_low_n <= next_irq_n;       // R8
        end
    end

    // read data, one edge behind the index;
    // the host holds the index for that edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;                     // R2
        end
    end

    // button hold divider and ms count;
    // both idle at zero while released
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt  <= 32'h00000000;
            hold_ms <= 14'h0000;
        end else begin
            ms_cnt  <= next_ms_cnt;
            hold_ms <= next_hold_ms;                     // R13
        end
    end

    // lead time countdown and shutdown pulse,
    // kept in a flop so the output is clean
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            warn_cnt     <= 23'h000000;
            shutdown_now <= 1'b0;
        end else begin
            warn_cnt     <= next_warn_cnt;
            shutdown_now <= next_shutdown;               // R11
        end
    end
endmodule

// ==== verif/pim_interrupt_core_asserts.sv ====
// Purpose: port-level checks of the interrupt collection core
// Assumes: single sys_clk domain, bound to pim_interrupt_core
// Notes:   lead time is timed for fuse code 01 only
`timescale 1ns/1ps
module pim_irq_checker
    import pim_pkg::*;
#(
    parameter int EWARN_C1_P = 10
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [4:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] status1_event,
    input wire logic [7:0] thermal_event,
    input wire logic [2:0] mode_event,
    input wire logic [2:0] ilim_event,
    input wire logic [2:0] uv_event,
    input wire logic [2:0] ov_event,
    input wire logic       push_event,
    input wire logic       release_event,
    input wire logic       bandgap_event,
    input wire logic [2:0] ilim_level,
    input wire logic       push_button_input,
    input wire logic       shutdown_request,
    input wire logic [1:0] warning_lead_time_fuse,
    input wire logic       shutdown_now,
    input wire logic       interrupt_request_low_n
);
    localparam int EW_DLY = EWARN_C1_P + 1; // load on request edge, pulse seen one edge after expiry
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // any source that may pull the line low
    logic any_src;
    assign any_src = |{status1_event, thermal_event, mode_event, ilim_event, uv_event, ov_event,
                       push_event, release_event, bandgap_event, shutdown_request, reg_wr, !push_button_input};
    property p_irq_hold; !interrupt_request_low_n && !reg_wr |=> !interrupt_request_low_n; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without a write");
    property p_irq_rise; $rose(interrupt_request_low_n) |-> $past(reg_wr); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose with no host write");
    property p_irq_fall; $fell(interrupt_request_low_n) |-> $past(any_src); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell with no cause");
    property p_ewarn_irq; shutdown_request |=> !interrupt_request_low_n; endproperty
    a_ewarn_irq: assert property (p_ewarn_irq) else $error("early warning did not assert irq");
    property p_sdn_time; shutdown_request && warning_lead_time_fuse == 2'b01 |-> ##EW_DLY shutdown_now; endproperty
    a_sdn_time: assert property (p_sdn_time) else $error("shutdown pulse mistimed");
    property p_sdn_pulse; shutdown_now |=> !shutdown_now; endproperty
    a_sdn_pulse: assert property (p_sdn_pulse) else $error("shutdown pulse too long");
    property p_unused_zero; reg_addr > SUMMARY || reg_addr == LIVE_BASE + 5'h02 |=> reg_rdata == 8'h00; endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused place read nonzero");
    property p_live_ilim; reg_addr == LIVE_BASE + 5'h03 |=> reg_rdata == {5'h00, $past(ilim_level)}; endproperty
    a_live_ilim: assert property (p_live_ilim) else $error("live bits not current");
    c_fall: cover property ($fell(interrupt_request_low_n));
    c_rise: cover property ($rose(interrupt_request_low_n));
    c_sdn: cover property (shutdown_now);
endmodule
bind pim_interrupt_core pim_irq_checker #(.EWARN_C1_P(EWARN_C1_P)) pim_irq_checker_i (.sys_clk, .rst_n,
    .reg_addr, .reg_wr, .reg_rdata, .status1_event, .thermal_event, .mode_event, .ilim_event, .uv_event,
    .ov_event, .push_event, .release_event, .bandgap_event, .ilim_level, .push_button_input,
    .shutdown_request, .warning_lead_time_fuse, .shutdown_now, .interrupt_request_low_n);

// ==== verif/pim_host_model.sv ====
// Purpose: host side of the register port
// Assumes: requests start 1 ns after a rising edge
// Notes:   write data is inverted once released
`timescale 1ns/1ps
module pim_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [4:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata
);
    // idle on an unused index
    initial begin
        reg_addr = 5'h1f;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // one register write; on a latch a one clears, a zero leaves the bit alone
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
        reg_wdata = ~d;
        // an idle edge, so two writes never touch
        @(posedge sys_clk);
        #1;
    endtask
    // read data is registered one edge after the index
    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        reg_addr = a;
        @(posedge sys_clk);
        #1 q = reg_rdata;
    endtask
endmodule

// ==== verif/tb.sv ====
// Purpose: self-checking bench of the interrupt collection core
// Assumes: shortened tick and lead-time counts
// Notes:   only the 1 s button hold is reached
`timescale 1ns/1ps
module tb;
    import pim_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, pb = 1'b1, sr = 1'b0, pe = 1'b0, shutdown_now, irq_n;
    logic [7:0] s1e = 8'h00, the = 8'h00, lv = 8'h00, rdata, wdata, q;
    logic [2:0] mde = 3'h0, ile = 3'h0, uve = 3'h0, ove = 3'h0;
    logic [4:0] addr;
    logic       rel = 1'b0, bge = 1'b0;
    logic [1:0] fuse = 2'b01;
    logic       wr;
    int fail_count = 0, checks_done = 0, n;
    pim_interrupt_core #(.MS_CYCLES_P(10), .EWARN_C0_P(5), .EWARN_C1_P(10), .EWARN_C2_P(15),
        .EWARN_C3_P(20)) pim_interrupt_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata), .status1_event(s1e), .thermal_event(the),
        .mode_event(mde), .ilim_event(ile), .uv_event(uve), .ov_event(ove), .push_event(pe),
        .release_event(rel), .bandgap_event(bge), .status1_level(lv[1:0]), .thermal_level(lv),
        .ilim_level(lv[2:0]), .uv_level(lv[2:0]), .ov_level(lv[2:0]), .bandgap_level(lv[7]),
        .push_button_input(pb), .enable_pin_level(lv[2:0]), .shutdown_request(sr),
        .warning_lead_time_fuse(fuse), .shutdown_now(shutdown_now), .interrupt_request_low_n(irq_n));
    pim_host_model pim_host_model_i (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wr(wr), .reg_wdata(wdata));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one-cycle pulse on bit 0 of group g
    task automatic fire(input int g);
        {pe, ove[0], uve[0], ile[0], mde[0], the[0], s1e[0]} = 7'(1 << g);
        @(posedge sys_clk);
        #1 {pe, ove[0], uve[0], ile[0], mde[0], the[0], s1e[0]} = 7'h00;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, about five times the ~10k cycles used
    initial begin
        #500000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            pim_host_model_i.rd(MASK_BASE + 5'(g), q); chk(q, MASK_RESET & LATCH_VALID[g]);
            pim_host_model_i.rd(LATCH_BASE + 5'(g), q); chk(q, 8'h00);
        end
        $display("reset test done");
        fire(1);
        pim_host_model_i.rd(LATCH_BASE + 5'h01, q); chk(q, 8'h01);
        pim_host_model_i.rd(SUMMARY, q); chk(q, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        pim_host_model_i.wr(MASK_BASE + 5'h01, 8'hfe); chk({7'h00, irq_n}, 8'h00);
        pim_host_model_i.wr(LATCH_BASE + 5'h01, 8'h00); chk({7'h00, irq_n}, 8'h00);
        pim_host_model_i.wr(LATCH_BASE + 5'h01, 8'h01); chk({7'h00, irq_n}, 8'h01);
        pim_host_model_i.rd(SUMMARY, q); chk(q, 8'h00);
        $display("mask test done");
        for (int g = 0; g < NUM_GROUPS; g++) begin
            pim_host_model_i.wr(MASK_BASE + 5'(g), 8'h00);
            fire(g);
            pim_host_model_i.rd(SUMMARY, q); chk(q, 8'(1 << g));
            pim_host_model_i.wr(LATCH_BASE + 5'(g), 8'h01); chk({7'h00, irq_n}, 8'h01);
        end
        ove = 3'b110;
        @(posedge sys_clk);
        #1 ove = 3'b000;
        pim_host_model_i.rd(LATCH_BASE + 5'h05, q); chk(q, 8'h06);
        pim_host_model_i.wr(LATCH_BASE + 5'h05, 8'h06);
        ile = 3'b001;
        fork
            pim_host_model_i.wr(LATCH_BASE + 5'h03, 8'h01);
            begin
                @(posedge sys_clk);
                #1 ile = 3'b000;
            end
        join
        pim_host_model_i.rd(LATCH_BASE + 5'h03, q); chk(q, 8'h01);
        pim_host_model_i.wr(LATCH_BASE + 5'h03, 8'h01);
        {bge, rel} = 2'b11;
        @(posedge sys_clk);
        #1 {bge, rel} = 2'b00;
        pim_host_model_i.rd(LATCH_BASE + 5'h06, q); chk(q, 8'h82);
        chk({7'h00, irq_n}, 8'h00);
        pim_host_model_i.wr(LATCH_BASE + 5'h06, 8'h82); chk({7'h00, irq_n}, 8'h01);
        $display("group test done");
        lv = 8'h85;
        pim_host_model_i.wr(LIVE_BASE + 5'h03, 8'h00);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            pim_host_model_i.rd(LIVE_BASE + 5'(g), q); chk(q, lv & LIVE_VALID[g]);
        end
        pim_host_model_i.rd(EN_LIVE, q); chk(q, 8'h05);
        pim_host_model_i.rd(5'h1f, q); chk(q, 8'h00);
        $display("live test done");
        // every fuse code; the instance is given lead counts 5, 10, 15, 20
        for (int f = 0; f < 4; f++) begin
            fuse = 2'(f);
            sr = 1'b1;
            @(posedge sys_clk);
            #1 sr = 1'b0;
            n = 0;
            while (shutdown_now !== 1'b1 && n < 40) begin
                @(posedge sys_clk);
                #1 n++;
            end
            chk(8'(n), 8'(5 * (f + 1)));
            pim_host_model_i.rd(SUMMARY, q); chk(q, 8'h80);
            pim_host_model_i.wr(SUMMARY, 8'h80); chk({7'h00, irq_n}, 8'h01);
        end
        $display("warning test done");
        pb = 1'b0;
        repeat (10050) @(posedge sys_clk);
        #1 pim_host_model_i.rd(LATCH_BASE + 5'h06, q); chk(q & 8'h3c, 8'h04);
        chk({7'h00, irq_n}, 8'h00);
        pb = 1'b1;
        $display("button test done");
        end_of_test();
    end
endmodule
